// *** sec_pkg.sv ***
// Package of constants, carrier structs and state type for the SPI control block.
// Function
// - Master with select pin enabled: low select sets fault.
// - Fault raises interrupt, clears enable and master.
// - Fault clears: status read, then control write.
// - Data write while busy flags collision, transfer continues.
// - Collision flag never requests an interrupt.
// - Collision clears: status access, then data access.
// - While done set, keep first byte, drop later.
// - Slave select rising mid-byte sets slave error.
// - Slave error clears only by writing enable 0.
// - Each finished byte sets done, requests interrupt.
// - Fault interrupt only while select pin enabled.
// - Control bit layout: rate2,en,select_pin_disable,master_select,clock_polarity,clock_phase,rate1,rate0.
// - Master rate codes divide clock 2..128; 111 invalid.
// - Select disable ignores select; slave needs phase 1.
// - Polarity sets serial clock idle level.
// - Phase picks leading or trailing sample edge.
// - Control resets to 0x14.
// - Status layout: done,collision,slave error,fault,reserved.
// - Enable bit disables or enables the interface.
// - Done clears: status read while set, then data read.
// - Data write loads shifter; read returns receive buffer.
// - Status flags reset to zero.
package sec_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [7:0] SEC_IDX_CTRL = 8'hC3;
  localparam logic [7:0] SEC_IDX_FLAGS = 8'hC4;
  localparam logic [7:0] SEC_IDX_DATA = 8'hC5;

  // Control register fields.
  localparam int SEC_CTRL_RATE2 = 7;
  localparam int SEC_CTRL_EN = 6;
  localparam int SEC_CTRL_SELECT_PIN_DISABLE = 5;
  localparam int SEC_CTRL_MASTER_SELECT = 4;
  localparam int SEC_CTRL_CLOCK_POLARITY = 3;
  localparam int SEC_CTRL_CLOCK_PHASE = 2;
  localparam int SEC_CTRL_RATE1 = 1;
  localparam int SEC_CTRL_RATE0 = 0;
  localparam logic [7:0] SEC_CTRL_RST = 8'h14;

  // Status register fields.
  localparam int SEC_STA_DONE = 7;
  localparam int SEC_STA_WRITE_COLLISION_FLAG = 6;
  localparam int SEC_STA_SLAVE_SELECT_ERROR_FLAG = 5;
  localparam int SEC_STA_MODE_FAULT_FLAG = 4;

  // Rate code that has no divider behind it.
  localparam logic [2:0] SEC_RATE_NONE = 3'h7;
  // Serial clock edges in one byte.
  localparam logic [4:0] SEC_EDGES_BYTE = 5'h10;

  typedef enum logic [1:0] {
    SEC_IDLE = 2'b01,
    SEC_BUSY = 2'b10
  } sec_state_e;

  // Serial pins as seen from outside the clock domain.
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } sec_pins_in_s;

  // Pin drivers, each with its enable.
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } sec_pins_out_s;

  typedef struct packed {
    sec_state_e st;
    logic [7:0] ctrl;
    logic done;
    logic write_collision_flag;
    logic slave_select_error_flag;
    logic mode_fault_flag;
    logic done_arm;
    logic write_collision_flag_arm;
    logic mode_fault_flag_arm;
    logic [7:0] shift;
    logic [7:0] rx_buf;
    logic samp;
    logic out_bit;
    logic sck_lvl;
    logic [4:0] edges;
    logic [6:0] div_cnt;
    sec_pins_in_s sync1;
    sec_pins_in_s sync2;
    logic sck_prev;
    logic [31:0] prdata;
  } sec_state_s;

  // Select idles high, so a master does not flag a fault just after reset.
  localparam sec_state_s SEC_STATE_RST = '{
    st: SEC_IDLE,
    ctrl: SEC_CTRL_RST,
    sync1: '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1},
    sync2: '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss_n: 1'b1},
    default: '0
  };

endpackage

// *** sec_slave_model.sv ***
// Remote SPI slave answering the master on the serial pins.
`timescale 1ns/1ps
module sec_slave_model (
  // Serial pins.
  input wire logic sck,
  input wire logic sck_oe,
  input wire logic mosi,
  output logic miso,
  // Reply byte and captured byte.
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  int n = 0;
  initial miso = 1'b0;
  // Phase 1 only: drive on the leading edge, sample on the trailing one.
  always @(sck) begin
    if (sck_oe) begin
      if (n % 2 == 0) miso = tx[7 - n / 2];
      else rx = {rx[6:0], mosi};
      n = (n + 1) % 16;
      // Line released after the byte shows a changed level, not the last.
      if (n == 0) miso = ~miso;
    end
  end
endmodule

// *** sec_spi_ctrl.sv ***
// SPI control, status, error flags and byte shifter behind an APB slave.
`timescale 1ns/1ps
module sec_spi_ctrl #(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins.
  input wire sec_pkg::sec_pins_in_s pins_i,
  output sec_pkg::sec_pins_out_s pins_o,
  // Interrupt request to the CPU.
  output logic irq
);
  import sec_pkg::*;

  sec_state_s s_r;
  sec_state_s s_nxt;

  //////////////////////////////////////////////////////////////////////////
  logic acc;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic hit;
  logic is_ctrl;
  logic is_flags;
  logic is_data;
  logic setup_hit;
  logic upper_ok;
  logic aligned;

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  // Bits above the index must be zero, or a far word would alias a register.
  assign upper_ok = (paddr >> 10) == '0;
  assign aligned = upper_ok && (paddr[1:0] == 2'h0);
  assign idx = 8'(paddr[ADDR_W-1:2]);
  assign is_ctrl = aligned && (idx == SEC_IDX_CTRL);
  assign is_flags = aligned && (idx == SEC_IDX_FLAGS);
  assign is_data = aligned && (idx == SEC_IDX_DATA);
  assign hit = is_ctrl | is_flags | is_data;
  assign setup_hit = psel & ~penable;

  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = s_r.prdata;

  //////////////////////////////////////////////////////////////////////////
  logic en;
  logic master_select;
  logic select_pin_disable;
  logic clock_polarity;
  logic clock_phase;
  logic [2:0] rate;
  logic [7:0] flags;

  assign en = s_r.ctrl[SEC_CTRL_EN];
  assign master_select = s_r.ctrl[SEC_CTRL_MASTER_SELECT];
  assign select_pin_disable = s_r.ctrl[SEC_CTRL_SELECT_PIN_DISABLE];
  assign clock_polarity = s_r.ctrl[SEC_CTRL_CLOCK_POLARITY];
  assign clock_phase = s_r.ctrl[SEC_CTRL_CLOCK_PHASE];
  assign rate = {s_r.ctrl[SEC_CTRL_RATE2], s_r.ctrl[SEC_CTRL_RATE1],
                 s_r.ctrl[SEC_CTRL_RATE0]};
  // Reserved status bits read as zero.
  assign flags[SEC_STA_DONE] = s_r.done;
  assign flags[SEC_STA_WRITE_COLLISION_FLAG] = s_r.write_collision_flag;
  assign flags[SEC_STA_SLAVE_SELECT_ERROR_FLAG] = s_r.slave_select_error_flag;
  assign flags[SEC_STA_MODE_FAULT_FLAG] = s_r.mode_fault_flag;
  assign flags[3:0] = 4'h0;

  // A transfer-done request or an enabled fault request.
  logic fault_req;
  assign fault_req = s_r.mode_fault_flag & ~select_pin_disable;
  // The collision flag is left out: it never asks for service.
  assign irq = s_r.done | fault_req;

  // Master drives the clock and MOSI; a selected slave drives MISO.
  logic slave_sel;
  assign slave_sel = ~s_r.sync2.ss_n | (select_pin_disable & clock_phase);
  assign pins_o.sck = s_r.sck_lvl;
  assign pins_o.sck_oe = en & master_select;
  assign pins_o.mosi = s_r.out_bit;
  assign pins_o.mosi_oe = en & master_select;
  assign pins_o.miso = s_r.out_bit;
  assign pins_o.miso_oe = en & ~master_select & slave_sel;

  //////////////////////////////////////////////////////////////////////////
  // Register side events, one per kind of access that a flag listens to.
  logic stat_rd;
  logic stat_acc;
  logic data_rd;
  logic data_acc;
  logic data_wr;
  logic ctrl_wr;
  logic ctrl_wr_off;
  logic [7:0] wr_byte;

  assign wr_byte = pwdata[7:0];
  assign stat_rd = rd & is_flags;
  assign stat_acc = acc & is_flags;
  assign data_rd = rd & is_data;
  assign data_acc = acc & is_data;
  assign data_wr = wr & is_data;
  assign ctrl_wr = wr & is_ctrl;
  assign ctrl_wr_off = ctrl_wr & ~wr_byte[SEC_CTRL_EN];

  // Read word picked in the setup cycle; unmapped words read as zero.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_ctrl) begin
      rd_word = {24'h00_0000, s_r.ctrl};
    end
    if (is_flags) begin
      rd_word = {24'h00_0000, flags};
    end
    if (is_data) begin
      rd_word = {24'h00_0000, s_r.rx_buf};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Select pin conditions, all on the synchronised copy of the pin.
  logic sel_used;
  logic fault_now;
  logic sel_lost;
  logic phase0_drop;

  assign sel_used = ~(select_pin_disable & clock_phase);
  assign fault_now = master_select & ~select_pin_disable & ~s_r.sync2.ss_n;
  assign sel_lost = ~master_select & en & sel_used & s_r.sync2.ss_n &
                    (s_r.edges != 5'h0);
  // A phase 0 slave frames each byte by select, so release ends it.
  assign phase0_drop = ~master_select & ~clock_phase & s_r.sync2.ss_n &
                       (s_r.st == SEC_BUSY);

  //////////////////////////////////////////////////////////////////////////
  // Serial clock strobes for both modes.
  logic [6:0] half_cnt;
  logic mst_busy;
  logic mst_tick;
  logic mst_lead;
  logic mst_trail;
  logic slv_active;
  logic sck_moved;
  logic slv_lead;
  logic slv_trail;

  assign half_cnt = 7'((8'h01 << rate) - 8'h01);
  assign mst_busy = master_select & (s_r.st == SEC_BUSY);
  assign mst_tick = mst_busy & (s_r.div_cnt == 7'h0);
  assign mst_lead = mst_tick & (s_r.sck_lvl == clock_polarity);
  assign mst_trail = mst_tick & (s_r.sck_lvl != clock_polarity);
  // A slave sees its clock late by the synchronisers; slow clocks only.
  assign slv_active = en & ~master_select & slave_sel;
  assign sck_moved = s_r.sync2.sck ^ s_r.sck_prev;
  assign slv_lead = slv_active & sck_moved & (s_r.sck_prev == clock_polarity);
  assign slv_trail = slv_active & sck_moved & (s_r.sck_prev != clock_polarity);

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic lead;
    logic trail;
    logic din;
    logic [7:0] nshift;
    lead = 1'b0;
    trail = 1'b0;
    din = 1'b0;
    nshift = 8'h00;
    s_nxt = s_r;

    // Pin synchronisers.
    s_nxt.sync1 = pins_i;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sck_prev = s_r.sync2.sck;

    // Read data is captured in the setup cycle for the access cycle.
    if (setup_hit) begin
      s_nxt.prdata = rd_word;
    end

    // Clearing sequences; hardware sets below take priority.
    if (stat_rd) begin
      s_nxt.done_arm = s_r.done;
      s_nxt.mode_fault_flag_arm = s_r.mode_fault_flag;
    end
    if (stat_acc) begin
      s_nxt.write_collision_flag_arm = s_r.write_collision_flag;
    end
    if (data_rd && s_r.done_arm) begin
      s_nxt.done = 1'b0;
      s_nxt.done_arm = 1'b0;
    end
    if (data_acc && s_r.write_collision_flag_arm) begin
      s_nxt.write_collision_flag = 1'b0;
      s_nxt.write_collision_flag_arm = 1'b0;
    end
    if (ctrl_wr) begin
      s_nxt.ctrl = wr_byte;
      if (s_r.mode_fault_flag_arm) begin
        s_nxt.mode_fault_flag = 1'b0;
        s_nxt.mode_fault_flag_arm = 1'b0;
      end
    end

    // Data write: loads the shifter when idle, else a collision.
    if (data_wr) begin
      if (s_r.st == SEC_BUSY) begin
        s_nxt.write_collision_flag = 1'b1;
      end else begin
        s_nxt.shift = pwdata[7:0];
        s_nxt.out_bit = pwdata[7];
        s_nxt.edges = 5'h0;
        if (master_select && en && rate != SEC_RATE_NONE) begin
          s_nxt.st = SEC_BUSY;
          s_nxt.div_cnt = 7'h0;
        end
      end
    end

    // Serial engine.
    if (master_select) begin
      din = s_r.sync2.miso;
      lead = mst_lead;
      trail = mst_trail;
      if (mst_tick) begin
        s_nxt.div_cnt = half_cnt;
        s_nxt.sck_lvl = ~s_r.sck_lvl;
      end else if (mst_busy) begin
        s_nxt.div_cnt = s_r.div_cnt - 7'h1;
      end else begin
        s_nxt.sck_lvl = clock_polarity;
      end
    end else begin
      din = s_r.sync2.mosi;
      lead = slv_lead;
      trail = slv_trail;
      s_nxt.sck_lvl = clock_polarity;
      // Phase 0 slaves start on select; phase 1 on the first edge.
      if (slv_active && (~clock_phase || slv_lead)) begin
        s_nxt.st = SEC_BUSY;
      end
    end

    // Phase 0 samples leaving idle, phase 1 returning to idle.
    nshift = s_r.shift;
    if (lead) begin
      if (!clock_phase) begin
        s_nxt.samp = din;
      end else begin
        s_nxt.out_bit = s_r.shift[7];
      end
    end
    if (trail) begin
      if (!clock_phase) begin
        nshift = {s_r.shift[6:0], s_r.samp};
        s_nxt.out_bit = s_r.shift[6];
      end else begin
        nshift = {s_r.shift[6:0], din};
      end
      s_nxt.shift = nshift;
    end
    if (lead || trail) begin
      s_nxt.edges = s_r.edges + 5'h1;
      if (s_r.edges + 5'h1 == SEC_EDGES_BYTE) begin
        s_nxt.edges = 5'h0;
        s_nxt.st = SEC_IDLE;
        // Later bytes are dropped while done is pending.
        if (!s_nxt.done) begin
          s_nxt.rx_buf = nshift;
        end
        s_nxt.done = 1'b1;
      end
    end

    // Writing enable 0 clears the slave error; a fresh error still wins.
    if (ctrl_wr_off) begin
      s_nxt.slave_select_error_flag = 1'b0;
    end

    // Select released mid-byte; a select-less slave cannot see it.
    if (sel_lost) begin
      s_nxt.slave_select_error_flag = 1'b1;
      s_nxt.st = SEC_IDLE;
      s_nxt.edges = 5'h0;
    end
    if (phase0_drop) begin
      s_nxt.st = SEC_IDLE;
    end

    // Another master pulled select low: drop to a disabled slave.
    if (fault_now) begin
      s_nxt.mode_fault_flag = 1'b1;
      s_nxt.ctrl[SEC_CTRL_EN] = 1'b0;
      s_nxt.ctrl[SEC_CTRL_MASTER_SELECT] = 1'b0;
    end

    // Disabling aborts any byte and resets the engine.
    if (!s_nxt.ctrl[SEC_CTRL_EN]) begin
      s_nxt.st = SEC_IDLE;
      s_nxt.edges = 5'h0;
      s_nxt.div_cnt = 7'h0;
      s_nxt.sck_lvl = s_nxt.ctrl[SEC_CTRL_CLOCK_POLARITY];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags come out of reset clear; the slave error is cleared too.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= SEC_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// *** sec_spi_ctrl_checker.sv ***
// Port-level assertions for the SPI control block.
`timescale 1ns/1ps
module sec_spi_ctrl_checker #(
  parameter int ADDR_W = 12
) (
  // Clock, reset and APB.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial pins and interrupt.
  input wire sec_pkg::sec_pins_in_s pins_i,
  input wire sec_pkg::sec_pins_out_s pins_o,
  input wire logic irq
);
  import sec_pkg::*;
  logic acc, on_c, on_f, on_d;
  logic [7:0] ctl_r;
  assign acc = psel && penable;
  assign on_c = paddr == ADDR_W'({SEC_IDX_CTRL, 2'h0});
  assign on_f = paddr == ADDR_W'({SEC_IDX_FLAGS, 2'h0});
  assign on_d = paddr == ADDR_W'({SEC_IDX_DATA, 2'h0});
  // Shadow of written control; hardware clears never touch the bits used.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_r <= SEC_CTRL_RST;
    else if (acc && pwrite && on_c) ctl_r <= pwdata[7:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ss_low3;
    (pins_o.sck_oe && !ctl_r[SEC_CTRL_SELECT_PIN_DISABLE] && !pins_i.ss_n) [*3];
  endsequence
  a_ready_now: assert property (acc |-> pready)
    else $error("pready low in access");
  a_err_map: assert property (acc |-> pslverr == !(on_c || on_f || on_d))
    else $error("pslverr wrong for address");
  a_rd_unmap: assert property (acc && !pwrite && pslverr |-> prdata == '0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (acc |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_fault_stop: assert property (
    ss_low3 |-> ##[0:3] (!pins_o.sck_oe && irq))
    else $error("mode fault did not stop master");
  a_irq_hold: assert property (
    irq && !(acc && (on_d || (pwrite && on_c))) |=> irq)
    else $error("irq dropped without clearing access");
  a_sck_rate: assert property (
    pins_o.sck_oe && {ctl_r[7], ctl_r[1:0]} == 3'h2 && $changed(pins_o.sck)
    |=> $stable(pins_o.sck) [*3])
    else $error("serial clock period wrong");
  a_miso_sel: assert property (
    pins_o.miso_oe && !ctl_r[SEC_CTRL_SELECT_PIN_DISABLE] |-> !$past(pins_i.ss_n, 2))
    else $error("miso driven while not selected");
endmodule
bind sec_spi_ctrl sec_spi_ctrl_checker #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins_i(pins_i), .pins_o(pins_o),
  .irq(irq));

// *** tb.sv ***
// Self-checking bench for the SPI control block.
`timescale 1ns/1ps
module tb;
  import sec_pkg::*;
  localparam logic [11:0] AC = {2'h0, SEC_IDX_CTRL, 2'h0};
  localparam logic [11:0] AF = {2'h0, SEC_IDX_FLAGS, 2'h0};
  localparam logic [11:0] AD = {2'h0, SEC_IDX_DATA, 2'h0};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic sk, ssn, mi, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] tx, rx, d;
  sec_pins_in_s pi;
  sec_pins_out_s po;
  int n_fail = 0, total_checks = 0, cyc = 0;
  assign pi = {sk, 1'b0, mi, ssn};
  sec_spi_ctrl #(.ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_i(pi), .pins_o(po), .irq(irq));
  sec_slave_model M (.sck(po.sck), .sck_oe(po.sck_oe), .mosi(po.mosi),
    .miso(mi), .tx(tx), .rx(rx));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, logic [7:0] v);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata[7:0];
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rchk(input logic [11:0] a, logic [7:0] e, string nm);
    apb(0, a, 8'h00);
    chk(nm, e, d);
  endtask
  task automatic wirq();
    repeat (400) if (irq !== 1'b1) @(posedge pclk);
    chk("irq", 8'h01, {7'h0, irq});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    sk = 0;
    ssn = 1;
    tx = 8'h96;
    presetn = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rchk(AC, 8'h14, "ctrl");
    rchk(AF, 8'h00, "flags");
    rchk(12'h004, 8'h00, "unmapped");
    chk("slverr", 8'h01, {7'h0, er});
    apb(1, AC, 8'h56);
    apb(1, AD, 8'hA5);
    apb(1, AD, 8'h3C);
    wirq();
    rchk(AF, 8'hC0, "flags");
    rchk(AD, 8'h96, "data");
    chk("remote", 8'hA5, rx);
    rchk(AF, 8'h00, "flags");
    tx = 8'h11;
    apb(1, AD, 8'h01);
    wirq();
    tx = 8'h22;
    apb(1, AD, 8'h02);
    repeat (100) @(posedge pclk);
    rchk(AF, 8'h80, "flags");
    rchk(AD, 8'h11, "data");
    ssn <= 0;
    repeat (8) @(posedge pclk);
    chk("irq", 8'h01, {7'h0, irq});
    rchk(AC, 8'h06, "ctrl");
    ssn <= 1;
    apb(1, AC, 8'h06);
    rchk(AF, 8'h10, "flags");
    apb(1, AC, 8'h16);
    apb(1, AC, 8'h76);
    rchk(AF, 8'h00, "flags");
    ssn <= 0;
    repeat (8) @(posedge pclk);
    rchk(AF, 8'h00, "flags");
    chk("irq", 8'h00, {7'h0, irq});
    ssn <= 1;
    apb(1, AC, 8'h44);
    ssn <= 0;
    repeat (4) @(posedge pclk);
    sk <= 1;
    repeat (4) @(posedge pclk);
    sk <= 0;
    repeat (4) @(posedge pclk);
    ssn <= 1;
    repeat (6) @(posedge pclk);
    rchk(AF, 8'h20, "flags");
    chk("irq", 8'h00, {7'h0, irq});
    apb(1, AC, 8'h04);
    rchk(AF, 8'h00, "flags");
    close_out();
  end
endmodule
